/* File: logic/tpwm_regs.vh */
// register offsets, fields and resets for the programmable waveform timer
`ifndef TPWM_REGS_VH
`define TPWM_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TPWM_OFF_MODE     8'h80
`define TPWM_OFF_WOC      8'h84
`define TPWM_OFF_PRIMARY  8'h88
`define TPWM_OFF_SECOND   8'h8c
`define TPWM_OFF_PRESC    8'h90
`define TPWM_OFF_OSEL     8'h94
`define TPWM_OFF_STATUS   8'h98
`define TPWM_OFF_MASK     8'h9c
`define TPWM_OFF_SRCDIV   8'ha0
`define TPWM_OFF_PORT     8'ha4
// ----------------------------------------
// field positions
// ----------------------------------------
`define TPWM_MODE_LO_BIT  4
`define TPWM_MODE_HI_BIT  5
`define TPWM_WC_BIT       6
`define TPWM_RUN_BIT      7
`define TPWM_LVL_BIT      5
`define TPWM_WAVE_MODE    2'h1
// ----------------------------------------
// reset values
// ----------------------------------------
`define TPWM_RST_MODE     8'h00
`define TPWM_RST_WOC      8'h00
`define TPWM_RST_RELOAD   8'hff
`define TPWM_RST_SRCDIV   8'h00
`endif

/* File: logic/tpwm_timer.v */
// programmable waveform generation timer with axi4-lite register slave
`timescale 1ns/10ps
`include "tpwm_regs.vh"
module tpwm_timer (
   // clock and reset
   input  wire        clk,
   input  wire        reset,
   // axi4-lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // pin and interrupt
   output reg         wave_out_pin,
   output reg         irq
);

// ----------------------------------------
// registers
// ----------------------------------------
reg  [7:0]  timer_mode;
reg  [7:0]  waveform_output_control;
reg  [7:0]  primary_reload;
reg  [7:0]  secondary_reload;
reg  [7:0]  prescaler_reload;
reg         output_switch_select;
reg         port_latch_bit;
reg  [7:0]  src_div;
reg  [1:0]  status;
reg  [1:0]  mask;
// values in use by the counter
reg  [7:0]  act_primary;
reg  [7:0]  act_secondary;
reg         pend_load;
reg         osel_act;
reg         osel_use;
// counters
reg  [7:0]  src_cnt;
reg  [7:0]  pre_cnt;
reg  [7:0]  main_cnt;
reg         in_second;
reg         wave;
reg         run_q;
// bus state
reg  [7:0]  aw_addr;
reg         aw_full;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         w_full;

wire op_mode_sel_lo = timer_mode[`TPWM_MODE_LO_BIT];
wire op_mode_sel_hi = timer_mode[`TPWM_MODE_HI_BIT];
wire write_ctrl     = timer_mode[`TPWM_WC_BIT];
wire count_run      = timer_mode[`TPWM_RUN_BIT];
wire output_level_sel = waveform_output_control[`TPWM_LVL_BIT];
wire wave_mode = ({op_mode_sel_hi, op_mode_sel_lo} == `TPWM_WAVE_MODE);
wire active    = wave_mode & count_run;
wire start     = active & ~run_q;

// ----------------------------------------
// count source and prescaler
// ----------------------------------------
wire src_tick = active & (src_cnt == 8'h00);
wire pre_uf   = src_tick & (pre_cnt == 8'h00);
wire main_uf  = pre_uf & (main_cnt == 8'h00);
wire sec_end  = main_uf & in_second;

// ----------------------------------------
// bus write decode
// ----------------------------------------
wire do_wr = aw_full & w_full & ~s_axi_bvalid;
wire wr_lo = w_strb[0];
wire [7:0] wv = w_data[7:0];
wire wr_mode = do_wr & wr_lo & (aw_addr == `TPWM_OFF_MODE);
wire wr_pri  = do_wr & wr_lo & (aw_addr == `TPWM_OFF_PRIMARY);
wire wr_sec  = do_wr & wr_lo & (aw_addr == `TPWM_OFF_SECOND);
wire wr_pre  = do_wr & wr_lo & (aw_addr == `TPWM_OFF_PRESC);
wire stopped = ~count_run;
wire hit_wr  = (aw_addr == `TPWM_OFF_MODE) | (aw_addr == `TPWM_OFF_WOC)
             | (aw_addr == `TPWM_OFF_PRIMARY) | (aw_addr == `TPWM_OFF_SECOND)
             | (aw_addr == `TPWM_OFF_PRESC) | (aw_addr == `TPWM_OFF_OSEL)
             | (aw_addr == `TPWM_OFF_STATUS) | (aw_addr == `TPWM_OFF_MASK)
             | (aw_addr == `TPWM_OFF_SRCDIV) | (aw_addr == `TPWM_OFF_PORT);

always @(posedge clk) begin
   if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
   end else begin
      if (s_axi_awvalid & s_axi_awready) begin
         aw_addr <= s_axi_awaddr[7:0];
         aw_full <= 1'b1;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         w_full <= 1'b1;
         s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= hit_wr ? 2'h0 : 2'h2;
         aw_full <= 1'b0;
         w_full  <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
         s_axi_bvalid  <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
   end
end

// ----------------------------------------
// register file
// ----------------------------------------
always @(posedge clk) begin
   if (reset) begin
      timer_mode <= `TPWM_RST_MODE;
      waveform_output_control <= `TPWM_RST_WOC;
      primary_reload   <= `TPWM_RST_RELOAD;
      secondary_reload <= `TPWM_RST_RELOAD;
      prescaler_reload <= `TPWM_RST_RELOAD;
      output_switch_select <= 1'b0;
      port_latch_bit <= 1'b0;
      src_div <= `TPWM_RST_SRCDIV;
      mask    <= 2'h0;
      status  <= 2'h0;
   end else begin
      if (wr_mode)
         timer_mode <= wv;
      if (do_wr & wr_lo & (aw_addr == `TPWM_OFF_WOC))
         waveform_output_control <= wv;
      if (wr_pri)
         primary_reload <= wv;
      if (wr_sec)
         secondary_reload <= wv;
      if (wr_pre)
         prescaler_reload <= wv;
      if (do_wr & wr_lo & (aw_addr == `TPWM_OFF_OSEL))
         output_switch_select <= wv[0];
      if (do_wr & wr_lo & (aw_addr == `TPWM_OFF_PORT))
         port_latch_bit <= wv[0];
      if (do_wr & wr_lo & (aw_addr == `TPWM_OFF_SRCDIV))
         src_div <= wv;
      if (do_wr & wr_lo & (aw_addr == `TPWM_OFF_MASK))
         mask <= wv[1:0];
      // set wins over write-one clear
      status[0] <= sec_end | (status[0] &
                   ~(do_wr & wr_lo & (aw_addr == `TPWM_OFF_STATUS) & wv[0]));
      status[1] <= start | (status[1] &
                   ~(do_wr & wr_lo & (aw_addr == `TPWM_OFF_STATUS) & wv[1]));
   end
end

// ----------------------------------------
// counter core
// ----------------------------------------
wire [7:0] next_main = in_second ? act_primary : act_secondary;

always @(posedge clk) begin
   if (reset) begin
      act_primary   <= `TPWM_RST_RELOAD;
      act_secondary <= `TPWM_RST_RELOAD;
      pend_load <= 1'b0;
      osel_act  <= 1'b0;
      osel_use  <= 1'b0;
      src_cnt   <= 8'h00;
      pre_cnt   <= `TPWM_RST_RELOAD;
      main_cnt  <= `TPWM_RST_RELOAD;
      in_second <= 1'b0;
      wave      <= 1'b0;
      run_q     <= 1'b0;
   end else begin
      run_q <= active;
      if (wr_pri)
         pend_load <= 1'b1;
      if (stopped) begin
         if (wr_pri | wr_sec) begin
            act_primary   <= wr_pri ? wv : primary_reload;
            act_secondary <= wr_sec ? wv : secondary_reload;
            pend_load <= 1'b0;
         end
         if (wr_pri)
            main_cnt <= wv;
         if (wr_pre)
            pre_cnt <= wv;
      end
      if (start) begin
         osel_act  <= output_switch_select;
         osel_use  <= output_switch_select;
         in_second <= 1'b0;
         main_cnt  <= act_primary;
         pre_cnt   <= prescaler_reload;
         src_cnt   <= src_div;
         wave      <= 1'b0;
      end else if (active) begin
         src_cnt <= (src_cnt == 8'h00) ? src_div : src_cnt - 8'h01;
         if (src_tick)
            pre_cnt <= (pre_cnt == 8'h00) ? prescaler_reload : pre_cnt - 8'h01;
         if (pre_uf)
            main_cnt <= (main_cnt == 8'h00) ? next_main : main_cnt - 8'h01;
         if (main_uf) begin
            in_second <= ~in_second;
            wave      <= ~wave;
         end
         if (sec_end) begin
            osel_act <= output_switch_select;
            osel_use <= osel_act;
            if (pend_load) begin
               act_primary   <= primary_reload;
               act_secondary <= secondary_reload;
               main_cnt      <= primary_reload;
               // a primary write in this same cycle stays pending
               pend_load     <= wr_pri;
            end
         end
      end
   end
end

// ----------------------------------------
// pin, interrupt and read channel
// ----------------------------------------
always @(posedge clk) begin
   if (reset) begin
      wave_out_pin <= 1'b0;
      irq <= 1'b0;
   end else begin
      irq <= |(status & mask);
      if (osel_use)
         wave_out_pin <= port_latch_bit;
      else
         wave_out_pin <= (active ? wave : 1'b0) ^ output_level_sel ^ active;
   end
end

always @(posedge clk) begin
   if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
   end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case (s_axi_araddr[7:0])
         `TPWM_OFF_MODE:    s_axi_rdata <= {24'h0, timer_mode};
         `TPWM_OFF_WOC:     s_axi_rdata <= {24'h0, waveform_output_control};
         `TPWM_OFF_PRIMARY: s_axi_rdata <= {24'h0, main_cnt};
         `TPWM_OFF_SECOND:  s_axi_rdata <= {24'h0, secondary_reload};
         `TPWM_OFF_PRESC:   s_axi_rdata <= {24'h0, pre_cnt};
         `TPWM_OFF_OSEL:    s_axi_rdata <= {30'h0, osel_use, output_switch_select};
         `TPWM_OFF_STATUS:  s_axi_rdata <= {29'h0, in_second, status};
         `TPWM_OFF_MASK:    s_axi_rdata <= {30'h0, mask};
         `TPWM_OFF_SRCDIV:  s_axi_rdata <= {24'h0, src_div};
         `TPWM_OFF_PORT:    s_axi_rdata <= {31'h0, port_latch_bit};
         default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
         end
      endcase
   end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
   end
end

endmodule

/* File: verif/tpwm_chk.sv */
// port assertions for the waveform timer
`timescale 1ns/10ps
module tpwm_chk (
   // clock and reset
   input wire        clk,
   input wire        reset,
   // bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // pin
   input wire        wave_out_pin,
   input wire        irq
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr; s_wr |=> !s_axi_awready ##1 s_axi_bvalid; endproperty
   a_wr: assert property (p_wr) else $error("write not answered");
   property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_b_busy: assert property (p_b_busy) else $error("write taken during response");
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_once: assert property (p_b_once) else $error("write response repeated");
   property p_rd; s_rd |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_busy: assert property (p_r_busy) else $error("read taken during data");
   property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_once: assert property (p_r_once) else $error("read data repeated");
   property p_rd_err;
      s_rd ##0 (s_axi_araddr[7:0] > 8'ha4) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
   property p_rst;
      $fell(reset) |-> !wave_out_pin && !irq && s_axi_awready && !s_axi_bvalid;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

/* File: verif/tb_tpwm_timer.sv */
// self-checking bench for the waveform timer
`timescale 1ns/10ps
module tb_tpwm_timer;
   // ----------------------------------------
   // signals and tasks
   // ----------------------------------------
   reg         clk = 1'b0, reset = 1'b1;
   reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd_d;
   reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire        awready, wready, bvalid, arready, rvalid, pin, irq;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   reg  [1:0]  rd_r, wr_r;
   reg  [15:0] lf = 16'he96e;
   integer     mismatches = 0, n_compared = 0, cyc = 0, hi, lo, m, p, q, n, lv, v;
   tpwm_timer i_dut (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .wave_out_pin(pin), .irq(irq));
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         finish_test;
      end
   end
   function [15:0] nx(input [15:0] s);
      nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function integer plen(input integer r);
      plen = (n + 1) * (r + 1);
   endfunction
   task chk(input [31:0] seen, input [31:0] exp, input string what);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         awaddr <= {24'h0, a};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
         end
         wr_r = bresp;
         bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge clk);
         araddr <= {24'h0, a};
         arvalid <= 1'b1;
         rready <= 1'b1;
         forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
         end
         rd_d = rdata;
         rd_r = rresp;
         rready <= 1'b0;
      end
   endtask
   task meas;
      begin
         @(posedge clk);
         while (pin) @(posedge clk);
         while (!pin) @(posedge clk);
         hi = 0;
         while (pin) begin hi = hi + 1; @(posedge clk); end
         lo = 0;
         while (!pin) begin lo = lo + 1; @(posedge clk); end
      end
   endtask
   task finish_test;
      begin
         $display("compared %0d mismatches %0d", n_compared, mismatches);
         if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd(8'h80); chk(rd_d, 32'h0, "mode");
      rd(8'h84); chk(rd_d, 32'h0, "level");
      rd(8'hb0); chk(rd_r, 2'h2, "rresp");
      wr(8'hb0, 32'h1); chk(wr_r, 2'h2, "bresp");
      for (lv = 0; lv < 2; lv = lv + 1) begin
         lf = nx(lf);
         m = 1 + lf[2:0];
         p = 1 + lf[5:3];
         n = lf[6];
         wr(8'h80, 32'h50);
         wr(8'h84, lv << 5); wr(8'h90, n); wr(8'h8c, p); wr(8'h88, m);
         rd(8'h88); chk(rd_d[7:0], m, "counter");
         wr(8'h80, 32'hd0);
         meas; chk(hi, lv ? plen(p) : plen(m), "high");
         chk(lo, lv ? plen(m) : plen(p), "low");
      end
      q = 1 + lf[9:7];
      wr(8'h8c, q);
      meas; chk(hi, plen(p), "old secondary");
      rd(8'h88); chk(rd_r, 2'h0, "live read");
      v = 1 + lf[12:10];
      wr(8'h88, v);
      meas; chk(lo, plen(v), "new primary");
      meas; chk(hi, plen(q), "new secondary");
      chk(lo, plen(v), "new primary again");
      wr(8'h9c, 32'h0); meas; chk(irq, 1'b0, "masked irq");
      wr(8'h9c, 32'h1); repeat (2) @(posedge clk); chk(irq, 1'b1, "irq");
      wr(8'h80, 32'h50); wr(8'h98, 32'h3); repeat (2) @(posedge clk);
      chk(irq, 1'b0, "cleared irq");
      v = pin; repeat (30) @(posedge clk); chk(pin, v, "halted pin");
      wr(8'h94, 32'h1); wr(8'ha4, 32'h1); wr(8'h80, 32'hd0);
      repeat (80) @(posedge clk);
      repeat (20) begin @(posedge clk); chk(pin, 1'b1, "latch pin"); end
      finish_test;
   end
endmodule
bind tpwm_timer tpwm_chk i_chk (.clk(clk), .reset(reset),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .wave_out_pin(wave_out_pin), .irq(irq));
